// *** hw/spewc_pkg.sv ***
package spewc_pkg;

  // handshake bytes and command codes
  localparam logic [7:0] MATCH1_A       = 8'h86;
  localparam logic [7:0] MATCH1_B       = 8'h30;
  localparam logic [7:0] MATCH2_A       = 8'h79;
  localparam logic [7:0] MATCH2_B       = 8'hCF;
  localparam logic [7:0] OP_ERASE       = 8'hF0;
  localparam logic [7:0] OP_WRITE       = 8'h30;
  localparam logic [7:0] ERR_CMD        = 8'hA1;
  localparam logic [1:0] ERR_REPEAT     = 2'h3;

  // reply flags
  localparam logic [7:0] OVW_NONE       = 8'h55;
  localparam logic [7:0] OVW_HIT        = 8'hAA;

  // erase area code
  localparam logic [7:0] CHIP_ERASE_MIN = 8'h20;
  localparam logic [7:0] SECTOR_FIRST   = 8'h0C;
  localparam logic [7:0] SECTOR_LAST    = 8'h0F;
  localparam int         SECTOR_BYTES   = 4096;

  // flash map
  localparam logic [7:0]  ERASED        = 8'hFF;
  localparam int          FLASH_BYTES_DEF = 16384;
  localparam logic [15:0] BLANK_LO      = 16'hFFE0;
  localparam int          BLANK_BYTES   = 32;
  localparam logic [15:0] SECU_MARK     = 16'hFFFA;

  // binary hex records
  localparam logic [7:0] REC_DATA       = 8'h00;
  localparam logic [7:0] REC_EOF        = 8'h01;
  localparam logic [7:0] EOF_SUM        = 8'hFF;

  // host reply timeout in core_clk cycles, covers a whole chip erase
  localparam int REPLY_WAIT_DEF         = 20000;

endpackage : spewc_pkg

// *** hw/spewc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface spewc_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_err;
  logic       d2h_valid;
  logic [7:0] d2h_data;

  modport dev
  (
    input  h2d_valid, h2d_data, h2d_err,
    output d2h_valid, d2h_data
  );
  modport host
  (
    output h2d_valid, h2d_data, h2d_err,
    input  d2h_valid, d2h_data
  );
endinterface : spewc_link_if
`default_nettype wire

// *** hw/spewc_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module spewc_dev
  import spewc_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_BYTES_DEF
)
(
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  // serial link
  spewc_link_if.dev   link,
  // security control and status
  input  wire logic   set_security,
  output logic        security_on,
  output logic        stopped,
  output logic        hung
);

  localparam int          AW       = $clog2(FLASH_BYTES);
  localparam logic [16:0] FLASH_LO = 17'(65536 - FLASH_BYTES);

  typedef enum logic [4:0]
  {
    S_M1, S_M2, S_CMD, S_ERRTX, S_PADDR, S_PSTR, S_ERC, S_ERASE,
    S_HHDR, S_HDAT, S_HSUM, S_TXFLAG, S_TXSH, S_TXSL, S_STOP, S_HANG
  } spewc_dstate_t;

  function automatic logic in_flash(input logic [23:0] a);
    return (a[23:16] == 8'h00) && ({1'b0, a[15:0]} >= FLASH_LO);
  endfunction : in_flash

  function automatic logic [AW-1:0] fidx(input logic [15:0] a);
    logic [16:0] d;
    d = {1'b0, a} - FLASH_LO;
    return d[AW-1:0];
  endfunction : fidx

  logic [7:0]    mem [FLASH_BYTES];
  spewc_dstate_t state;
  logic          op_write;
  logic          chip_mode;
  logic [2:0]    cnt;
  logic [47:0]   addr_buf;
  logic [15:0]   pw_ptr;
  logic [7:0]    pw_left;
  logic [AW-1:0] ers_ptr;
  logic [16:0]   ers_left;
  logic [7:0]    rec_len;
  logic [15:0]   rec_addr;
  logic [7:0]    rec_type;
  logic [7:0]    rec_sum;
  logic          ovw;
  logic [15:0]   csum;
  logic          tx_valid;
  logic [7:0]    tx_data;
  logic          sec;
  logic          blank;
  logic          listening;
  logic          erase_we;
  logic          data_we;
  logic          hd_in;
  logic [7:0]    hd_old;
  logic [7:0]    hd_now;
  logic [47:0]   ab_next;
  logic [7:0]    rxb;
  logic          rx;
  logic          rxe;

  assign rx          = link.h2d_valid;
  assign rxb         = link.h2d_data;
  assign rxe         = link.h2d_err;
  assign link.d2h_valid = tx_valid;
  assign link.d2h_data  = tx_data;
  assign security_on = sec;
  assign stopped     = (state == S_STOP);
  assign hung        = (state == S_HANG);
  assign ab_next     = {addr_buf[39:0], rxb};
  assign hd_in       = in_flash({8'h00, rec_addr});
  assign hd_old      = mem[fidx(rec_addr)];
  assign hd_now      = (hd_old == ERASED) ? rxb : hd_old;
  assign erase_we    = (state == S_ERASE);
  assign data_we     = (state == S_HDAT) && rx && !rxe && (rec_type == REC_DATA) && hd_in
                       && (hd_old == ERASED);
  assign listening   = (state == S_M1) || (state == S_M2) || (state == S_CMD)
                       || (state == S_PADDR) || (state == S_PSTR) || (state == S_ERC)
                       || (state == S_HHDR) || (state == S_HDAT) || (state == S_HSUM);

  // top password area all erased means a blank part
  always_comb
  begin
    blank = 1'b1;
    for (int i = 0; i < BLANK_BYTES; i++)
    begin
      if (mem[fidx(BLANK_LO + 16'(i))] != ERASED)
      begin
        blank = 1'b0;
      end
    end
  end

  // flash array, plain always because the bench preloads it
  always @(posedge core_clk)
  begin
    if (erase_we)
    begin
      mem[ers_ptr] <= ERASED;
    end
    else if (data_we)
    begin
      mem[fidx(rec_addr)] <= rxb;
    end
  end

  // security state, set wins over the chip erase clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sec <= 1'b0;
    end
    else if (set_security)
    begin
      sec <= 1'b1;
    end
    else if (erase_we && chip_mode && ers_left == 17'h1)
    begin
      sec <= 1'b0;
    end
  end

  // command sequencer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= S_M1;
      op_write  <= 1'b0;
      chip_mode <= 1'b0;
      cnt       <= 3'h0;
      addr_buf  <= 48'h0;
      pw_ptr    <= 16'h0;
      pw_left   <= 8'h00;
      ers_ptr   <= '0;
      ers_left  <= 17'h0;
      rec_len   <= 8'h00;
      rec_addr  <= 16'h0;
      rec_type  <= 8'h00;
      rec_sum   <= 8'h00;
      ovw       <= 1'b0;
      csum      <= 16'h0;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
    end
    else
    begin
      tx_valid <= 1'b0;
      if (rx && rxe && listening)
      begin
        state <= S_STOP;
      end
      else
      begin
        unique case (state)
          S_M1:
            if (rx)
            begin
              if (rxb == MATCH1_A || rxb == MATCH1_B)
              begin
                tx_valid <= 1'b1;
                tx_data  <= rxb;
                state    <= S_M2;
              end
              else
              begin
                state <= S_STOP;
              end
            end
          S_M2:
            if (rx)
            begin
              if (rxb == MATCH2_A || rxb == MATCH2_B)
              begin
                tx_valid <= 1'b1;
                tx_data  <= rxb;
                state    <= S_CMD;
              end
              else
              begin
                state <= S_STOP;
              end
            end
          S_CMD:
            if (rx)
            begin
              cnt  <= 3'h0;
              csum <= 16'h0;
              ovw  <= 1'b0;
              if (rxb == OP_ERASE)
              begin
                tx_valid <= 1'b1;
                tx_data  <= rxb;
                op_write <= 1'b0;
                state    <= S_PADDR;
              end
              else if (rxb == OP_WRITE)
              begin
                op_write <= 1'b1;
                if (sec)
                begin
                  state <= S_STOP;
                end
                else
                begin
                  tx_valid <= 1'b1;
                  tx_data  <= rxb;
                  state    <= S_PADDR;
                end
              end
              else
              begin
                state <= S_ERRTX;
              end
            end
          S_ERRTX:
          begin
            tx_valid <= 1'b1;
            tx_data  <= ERR_CMD;
            cnt      <= cnt + 3'h1;
            if (cnt == 3'({1'b0, ERR_REPEAT}) - 3'h1)
            begin
              state <= S_STOP;
            end
          end
          S_PADDR:
            if (rx)
            begin
              addr_buf <= ab_next;
              cnt      <= cnt + 3'h1;
              if (cnt == 3'h5)
              begin
                cnt     <= 3'h0;
                pw_left <= mem[fidx(ab_next[39:24])];
                pw_ptr  <= ab_next[15:0];
                if (!in_flash(ab_next[47:24]) || !in_flash(ab_next[23:0]))
                begin
                  state <= S_STOP;
                end
                else if (blank)
                begin
                  state <= op_write ? S_HHDR : S_ERC;
                end
                else if (mem[fidx(ab_next[39:24])] == 8'h00)
                begin
                  state <= S_STOP;
                end
                else
                begin
                  state <= S_PSTR;
                end
              end
            end
          S_PSTR:
            if (rx)
            begin
              pw_ptr  <= pw_ptr + 16'h1;
              pw_left <= pw_left - 8'h1;
              if (!in_flash({8'h00, pw_ptr}) || rxb != mem[fidx(pw_ptr)])
              begin
                state <= S_STOP;
              end
              else if (pw_left == 8'h1)
              begin
                state <= op_write ? S_HHDR : S_ERC;
              end
            end
          S_ERC:
            if (rx)
            begin
              if (rxb >= CHIP_ERASE_MIN)
              begin
                chip_mode <= 1'b1;
                ers_ptr   <= '0;
                ers_left  <= 17'(FLASH_BYTES);
                state     <= S_ERASE;
              end
              else if (rxb < SECTOR_FIRST || rxb > SECTOR_LAST)
              begin
                state <= S_STOP;
              end
              else if (mem[fidx(SECU_MARK)] == ERASED || sec)
              begin
                state <= S_HANG;
              end
              else if (!in_flash({8'h00, rxb[3:0], 12'h000}))
              begin
                state <= S_STOP;
              end
              else
              begin
                chip_mode <= 1'b0;
                ers_ptr   <= fidx({rxb[3:0], 12'h000});
                ers_left  <= 17'(SECTOR_BYTES);
                state     <= S_ERASE;
              end
            end
          S_ERASE:
          begin
            ers_ptr  <= ers_ptr + AW'(1);
            ers_left <= ers_left - 17'h1;
            csum     <= csum + 16'(ERASED);
            if (ers_left == 17'h1)
            begin
              state <= S_TXSH;
            end
          end
          S_HHDR:
            if (rx)
            begin
              cnt     <= cnt + 3'h1;
              rec_sum <= (cnt == 3'h0) ? rxb : rec_sum + rxb;
              unique case (cnt)
                3'h0:    rec_len <= rxb;
                3'h1:    rec_addr[15:8] <= rxb;
                3'h2:    rec_addr[7:0] <= rxb;
                default:
                begin
                  rec_type <= rxb;
                  cnt      <= 3'h0;
                  if (rxb != REC_DATA && rxb != REC_EOF)
                  begin
                    state <= S_STOP;
                  end
                  else
                  begin
                    state <= (rec_len == 8'h00) ? S_HSUM : S_HDAT;
                  end
                end
              endcase
            end
          S_HDAT:
            if (rx)
            begin
              rec_sum  <= rec_sum + rxb;
              rec_addr <= rec_addr + 16'h1;
              rec_len  <= rec_len - 8'h1;
              if (rec_type == REC_DATA)
              begin
                csum <= csum + 16'(hd_now);
                if (hd_old != ERASED)
                begin
                  ovw <= 1'b1;
                end
              end
              if (rec_type == REC_DATA && !hd_in)
              begin
                state <= S_STOP;
              end
              else if (rec_len == 8'h1)
              begin
                state <= S_HSUM;
              end
            end
          S_HSUM:
            if (rx)
            begin
              if (8'(rec_sum + rxb) != 8'h00)
              begin
                state <= S_STOP;
              end
              else
              begin
                state <= (rec_type == REC_EOF) ? S_TXFLAG : S_HHDR;
              end
            end
          S_TXFLAG:
          begin
            tx_valid <= 1'b1;
            tx_data  <= ovw ? OVW_HIT : OVW_NONE;
            state    <= S_TXSH;
          end
          S_TXSH:
          begin
            tx_valid <= 1'b1;
            tx_data  <= csum[15:8];
            state    <= S_TXSL;
          end
          S_TXSL:
          begin
            tx_valid <= 1'b1;
            tx_data  <= csum[7:0];
            state    <= S_CMD;
          end
          S_STOP:  state <= S_STOP;
          S_HANG:  state <= S_HANG;
        endcase
      end
    end
  end

endmodule : spewc_dev
`default_nettype wire

// *** hw/spewc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spewc_host
  import spewc_pkg::*;
#(
  parameter int REPLY_WAIT = REPLY_WAIT_DEF
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // serial link
  spewc_link_if.host       link,
  // request
  input  wire logic        go,
  input  wire logic        op_erase,
  input  wire logic [7:0]  erase_code,
  input  wire logic [23:0] pw_cnt_addr,
  input  wire logic [23:0] pw_cmp_addr,
  input  wire logic [7:0]  pw_len,
  input  wire logic [15:0] rec_addr,
  input  wire logic [7:0]  rec_len,
  input  wire logic        line_fault,
  // password and record bytes
  input  wire logic        src_valid,
  input  wire logic [7:0]  src_data,
  output logic             src_ready,
  // result
  output logic             busy,
  output logic             done,
  output logic             fail,
  output logic             ovw_seen,
  output logic [15:0]      sum_out
);

  typedef enum logic [3:0]
  {
    H_IDLE, H_M1, H_M2, H_CMD, H_ADDR, H_PW, H_ERC, H_RHDR, H_RDAT,
    H_RCS, H_EOF, H_WAIT, H_RFLAG, H_RSH, H_RSL
  } spewc_hstate_t;

  spewc_hstate_t state;
  spewc_hstate_t after;
  logic [7:0]    exp_byte;
  logic          synced;
  logic          erase_op;
  logic [7:0]    code;
  logic [47:0]   addrs;
  logic [7:0]    plen;
  logic [15:0]   raddr;
  logic [7:0]    rlen;
  logic [2:0]    cnt;
  logic [7:0]    rcs;
  logic [31:0]   tmr;
  logic          tx_valid;
  logic [7:0]    tx_data;
  logic          rx;
  logic          waiting;
  logic [16:0]   rec_end;

  assign rx             = link.d2h_valid;
  assign link.h2d_valid = tx_valid;
  assign link.h2d_data  = tx_data;
  assign link.h2d_err   = tx_valid && line_fault;
  assign src_ready      = (state == H_PW) || (state == H_RDAT);
  assign busy           = (state != H_IDLE);
  assign waiting        = (state == H_WAIT) || (state == H_RFLAG)
                          || (state == H_RSH) || (state == H_RSL);
  assign rec_end        = {1'b0, rec_addr} + {9'h000, rec_len} - 17'h1;

  // reply timeout
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tmr <= 32'h0;
    end
    else
    begin
      tmr <= (waiting && !rx) ? tmr + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= H_IDLE;
      after    <= H_IDLE;
      exp_byte <= 8'h00;
      synced   <= 1'b0;
      erase_op <= 1'b0;
      code     <= 8'h00;
      addrs    <= 48'h0;
      plen     <= 8'h00;
      raddr    <= 16'h0;
      rlen     <= 8'h00;
      cnt      <= 3'h0;
      rcs      <= 8'h00;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      done     <= 1'b0;
      fail     <= 1'b0;
      ovw_seen <= 1'b0;
      sum_out  <= 16'h0;
    end
    else
    begin
      tx_valid <= 1'b0;
      done     <= 1'b0;
      if (waiting && tmr == 32'(REPLY_WAIT))
      begin
        fail   <= 1'b1;
        done   <= 1'b1;
        synced <= 1'b0;
        state  <= H_IDLE;
      end
      else
      begin
        unique case (state)
          H_IDLE:
            if (go)
            begin
              erase_op <= op_erase;
              code     <= erase_code;
              addrs    <= {pw_cnt_addr, pw_cmp_addr};
              plen     <= pw_len;
              raddr    <= rec_addr;
              rlen     <= rec_len;
              cnt      <= 3'h0;
              fail     <= 1'b0;
              ovw_seen <= 1'b0;
              if (!op_erase && rec_len != 8'h00 && rec_end >= {1'b0, BLANK_LO})
              begin
                fail <= 1'b1;
                done <= 1'b1;
                synced <= 1'b0;
              end
              else
              begin
                state <= synced ? H_CMD : H_M1;
              end
            end
          H_M1:
          begin
            tx_valid <= 1'b1;
            tx_data  <= MATCH1_A;
            exp_byte <= MATCH1_A;
            after    <= H_M2;
            state    <= H_WAIT;
          end
          H_M2:
          begin
            tx_valid <= 1'b1;
            tx_data  <= MATCH2_A;
            exp_byte <= MATCH2_A;
            after    <= H_CMD;
            state    <= H_WAIT;
          end
          H_CMD:
          begin
            tx_valid <= 1'b1;
            tx_data  <= erase_op ? OP_ERASE : OP_WRITE;
            exp_byte <= erase_op ? OP_ERASE : OP_WRITE;
            synced   <= 1'b1;
            after    <= H_ADDR;
            state    <= H_WAIT;
          end
          H_WAIT:
            if (rx)
            begin
              if (link.d2h_data == exp_byte)
              begin
                state <= after;
              end
              else
              begin
                fail   <= 1'b1;
                done   <= 1'b1;
                synced <= 1'b0;
                state  <= H_IDLE;
              end
            end
          H_ADDR:
          begin
            tx_valid <= 1'b1;
            tx_data  <= addrs[47:40];
            addrs    <= {addrs[39:0], 8'h00};
            cnt      <= cnt + 3'h1;
            if (cnt == 3'h5)
            begin
              cnt   <= 3'h0;
              state <= (plen != 8'h00) ? H_PW : (erase_op ? H_ERC : H_RHDR);
            end
          end
          H_PW:
            if (src_valid)
            begin
              tx_valid <= 1'b1;
              tx_data  <= src_data;
              plen     <= plen - 8'h1;
              if (plen == 8'h1)
              begin
                state <= erase_op ? H_ERC : H_RHDR;
              end
            end
          H_ERC:
          begin
            tx_valid <= 1'b1;
            tx_data  <= code;
            state    <= H_RSH;
          end
          H_RHDR:
          begin
            tx_valid <= 1'b1;
            cnt      <= cnt + 3'h1;
            unique case (cnt)
              3'h0:    tx_data <= rlen;
              3'h1:    tx_data <= raddr[15:8];
              3'h2:    tx_data <= raddr[7:0];
              default: tx_data <= REC_DATA;
            endcase
            unique case (cnt)
              3'h0:    rcs <= rlen;
              3'h1:    rcs <= rcs + raddr[15:8];
              3'h2:    rcs <= rcs + raddr[7:0];
              default: rcs <= rcs + REC_DATA;
            endcase
            if (cnt == 3'h3)
            begin
              cnt   <= 3'h0;
              state <= (rlen != 8'h00) ? H_RDAT : H_RCS;
            end
          end
          H_RDAT:
            if (src_valid)
            begin
              tx_valid <= 1'b1;
              tx_data  <= src_data;
              rcs      <= rcs + src_data;
              rlen     <= rlen - 8'h1;
              if (rlen == 8'h1)
              begin
                state <= H_RCS;
              end
            end
          H_RCS:
          begin
            tx_valid <= 1'b1;
            tx_data  <= 8'(8'h00 - rcs);
            state    <= H_EOF;
          end
          H_EOF:
          begin
            tx_valid <= 1'b1;
            tx_data  <= (cnt == 3'h3) ? REC_EOF : ((cnt == 3'h4) ? EOF_SUM : 8'h00);
            cnt      <= cnt + 3'h1;
            if (cnt == 3'h4)
            begin
              cnt   <= 3'h0;
              state <= H_RFLAG;
            end
          end
          H_RFLAG:
            if (rx)
            begin
              ovw_seen <= (link.d2h_data == OVW_HIT);
              state    <= H_RSH;
            end
          H_RSH:
            if (rx)
            begin
              sum_out[15:8] <= link.d2h_data;
              state         <= H_RSL;
            end
          H_RSL:
            if (rx)
            begin
              sum_out[7:0] <= link.d2h_data;
              done         <= 1'b1;
              state        <= H_IDLE;
            end
        endcase
      end
    end
  end

endmodule : spewc_host
`default_nettype wire

// *** tb/spewc_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module spewc_link_asserts
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       security_on,
  // link
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_err,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data
);
  logic [1:0] nb;
  logic       dead;
  wire  logic ok = h2d_valid && !h2d_err;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // position of the byte within the opening of the session
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) nb <= 2'h0;
    else if (h2d_valid && nb != 2'h3) nb <= nb + 2'h1;
  // link goes dead on a faulty byte or a wrong matching byte
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) dead <= 1'b0;
    else if (h2d_err || ok && nb == 2'h0 && !(h2d_data inside {8'h86, 8'h30})
             || ok && nb == 2'h1 && !(h2d_data inside {8'h79, 8'hCF})) dead <= 1'b1;
  chk_match1_echo: assert property (ok && nb == 2'h0 && h2d_data inside {8'h86, 8'h30}
    |=> d2h_valid && d2h_data == $past(h2d_data)) else $error("first byte not echoed");
  chk_match2_echo: assert property (ok && nb == 2'h1 && h2d_data inside {8'h79, 8'hCF}
    |=> d2h_valid && d2h_data == $past(h2d_data)) else $error("second byte not echoed");
  chk_write_echo: assert property (ok && nb == 2'h2 && h2d_data == 8'h30 && !security_on
    |=> d2h_valid && d2h_data == 8'h30) else $error("write command not echoed");
  chk_erase_echo: assert property (ok && nb == 2'h2 && h2d_data == 8'hF0
    |=> d2h_valid && d2h_data == 8'hF0) else $error("erase command not echoed");
  chk_bad_cmd_triple: assert property ($past(h2d_valid, 2) && d2h_valid && d2h_data == 8'hA1
    |=> (d2h_valid && d2h_data == 8'hA1) [*2] ##1 !d2h_valid [*8]) else $error("bad triple");
  chk_err_silent: assert property (h2d_err |=> !d2h_valid [*8])
    else $error("reply after faulty byte");
  chk_idle_mute: assert property (dead |-> !d2h_valid)
    else $error("dead link transmits");
  chk_err_with_byte: assert property (h2d_err |-> h2d_valid)
    else $error("fault flag without byte");
  cover property (ok && nb == 2'h2 && h2d_data == 8'h30);
  cover property (dead);
  cover property (d2h_valid && d2h_data == 8'hAA);
endmodule : spewc_link_asserts
`default_nettype wire

// *** tb/tb_serial_prom_erase_write_cmds.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_serial_prom_erase_write_cmds;
  import spewc_pkg::*;
  typedef struct packed {logic er; logic [7:0] code; logic [15:0] addr; logic [7:0] d;
                         logic ovw; logic [15:0] sum;} spewc_row_t;
  localparam int FB = 8192;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        go = 1'b0;
  logic        op_erase = 1'b0;
  logic        line_fault = 1'b0;
  logic        set_security = 1'b0;
  logic [7:0]  erase_code = 8'h00;
  logic [7:0]  pw_len = 8'h00;
  logic [7:0]  rec_len = 8'h00;
  logic [15:0] rec_addr = 16'h0000;
  int          idx = 0, cyc = 0, miscompares = 0, checked = 0;
  logic [7:0]  feed [2] = '{8'h00, 8'h00};
  wire  logic [7:0] src_data = feed[idx[0]];
  logic        src_ready, busy, done, fail, ovw_seen, security_on, stopped, hung;
  logic [15:0] sum_out;
  logic [7:0]  bad [6] = '{8'h0B, 8'h10, 8'h1F, 8'h0C, 8'h00, 8'h00};
  spewc_row_t  rows [4] = '{'{1'b0, 8'h00, 16'hE010, 8'h12, 1'b0, 16'h0012},
                           '{1'b0, 8'h00, 16'hE010, 8'h34, 1'b1, 16'h0012},
                           '{1'b1, 8'h0E, 16'h0000, 8'h00, 1'b0, 16'hF000},
                           '{1'b0, 8'h00, 16'hE010, 8'h56, 1'b0, 16'h0056}};
  spewc_link_if spewc_link_if_inst ();
  spewc_dev #(.FLASH_BYTES(FB)) spewc_dev_inst (.core_clk(core_clk), .arst_n(arst_n),
    .link(spewc_link_if_inst.dev), .set_security(set_security), .security_on(security_on),
    .stopped(stopped), .hung(hung));
  spewc_host #(.REPLY_WAIT(FB + 50)) spewc_host_inst (.core_clk(core_clk), .arst_n(arst_n),
    .link(spewc_link_if_inst.host), .go(go), .op_erase(op_erase), .erase_code(erase_code),
    .pw_cnt_addr(24'h00F000), .pw_cmp_addr(24'h00F001), .pw_len(pw_len), .rec_addr(rec_addr),
    .rec_len(rec_len), .line_fault(line_fault), .src_valid(1'b1), .src_data(src_data),
    .src_ready(src_ready), .busy(busy), .done(done), .fail(fail), .ovw_seen(ovw_seen),
    .sum_out(sum_out));
  spewc_link_asserts spewc_link_asserts_inst (.core_clk(core_clk), .arst_n(arst_n),
    .h2d_valid(spewc_link_if_inst.h2d_valid), .h2d_data(spewc_link_if_inst.h2d_data),
    .h2d_err(spewc_link_if_inst.h2d_err), .d2h_valid(spewc_link_if_inst.d2h_valid),
    .d2h_data(spewc_link_if_inst.d2h_data), .security_on(security_on));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (src_ready) idx <= idx + 1;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // password: one byte 5A at F001, and 00 at FFFA makes the top area not blank
  task automatic restart;
    arst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    for (int a = 0; a < FB; a++)
      spewc_dev_inst.mem[a] = 8'hFF;
    spewc_dev_inst.mem[13'h1000] = 8'h01;
    spewc_dev_inst.mem[13'h1001] = 8'h5A;
    spewc_dev_inst.mem[13'h1FFA] = 8'h00;
    arst_n = 1'b1;
  endtask : restart
  task automatic run(input logic er, input logic [7:0] code, input logic [15:0] addr,
                     input logic [7:0] d, input logic [7:0] pl);
    @(negedge core_clk);
    op_erase = er;
    erase_code = code;
    rec_addr = addr;
    rec_len = {7'h00, !er};
    pw_len = pl;
    feed = '{(pl != 8'h00) ? 8'h5A : d, d};
    idx = 0;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    for (int i = 0; i < 20000 && done !== 1'b1; i++)
      @(negedge core_clk);
    miscompares += (done !== 1'b1);
  endtask : run
  initial
  begin
    restart();
    check("reset", {12'h0, busy, stopped, hung, security_on}, 16'h0000);
    foreach (rows[r])
    begin
      run(rows[r].er, rows[r].code, rows[r].addr, rows[r].d, 8'h01);
      check("fail", {15'h0, fail}, 16'h0000);
      check("sum", sum_out, rows[r].sum);
      if (!rows[r].er) check("flag", {15'h0, ovw_seen}, {15'h0, rows[r].ovw});
    end
    run(1'b0, 8'h00, 16'hFFE8, 8'h11, 8'h01);
    check("top refused", {15'h0, fail}, 16'h0001);
    run(1'b0, 8'h00, 16'hE020, 8'h11, 8'h01);
    repeat (2) @(negedge core_clk);
    check("bad command", {15'h0, stopped}, 16'h0001);
    restart();
    @(negedge core_clk);
    set_security = 1'b1;
    @(negedge core_clk);
    set_security = 1'b0;
    check("secure", {15'h0, security_on}, 16'h0001);
    run(1'b1, 8'h20, 16'h0000, 8'h00, 8'h01);
    check("chip sum", sum_out, 16'hE000);
    check("secure", {15'h0, security_on}, 16'h0000);
    run(1'b1, 8'h0F, 16'h0000, 8'h00, 8'h00);
    check("hung", {15'h0, hung}, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      restart();
      set_security = (i == 4);
      fork
        run(i < 4, bad[i], 16'hE020, 8'h77, 8'h01);
        begin
          repeat (13) @(negedge core_clk);
          line_fault = (i == 5);
        end
      join
      line_fault = 1'b0;
      set_security = 1'b0;
      check("stopped", {15'h0, stopped}, 16'h0001);
      check("fail", {15'h0, fail}, 16'h0001);
    end
    give_verdict();
  end
endmodule : tb_serial_prom_erase_write_cmds
`default_nettype wire
